/* File: core/hpa_regs.sv */
// headphone amplifier control register bank with gain application
// assumes write/read strobes come from the serial control logic on core_clk_i
//
// Operation
// - right gain is a six-bit code in 1.5 dB steps, reset to the 0 dB code.
// - left gain uses the same six-bit code; its reset is a parameter.
// - code 0x15 is -57 dB, rising 1.5 dB per code to 0 dB at 0x3B and +6 dB at 0x3F.
// - right control bit 7 turns the right amplifier on, reset off.
// - right control bit 6 mutes the right amplifier, reset muted.
// - bit 5 makes gain changes glide a code at a time, and beats zero-cross timing.
// - bit 4 with gliding off applies a new gain only at a zero crossing.
// - right control bit 3 drives the output, clear leaves it floating, reset floating.
// - right control bit 2 holds the gain at its lowest code.
// - config bit 4 selects single rail when set, charge pump when clear, reset clear.
// - a change to the single rail bit needs the key 0xC3 written first.
// - the key register resets to 0xC3.
// - the left control register has the same layout and reset as the right one.
`default_nettype none
module hpa_regs
  import hpa_pkg::*;
#(
  parameter logic [5:0] LEFT_GAIN_RST = HPA_GAIN_RST_L,
  parameter int         GLIDE_CYCLES  = HPA_GLIDE_CYCLES
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   wr_en_i,
  input  wire logic                   rd_en_i,
  input  wire logic [7:0]             addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic [1:0]             zero_cross_i,
  output logic      [7:0]             rdata_o,
  output logic                        rvalid_o,
  output hpa_pkg::hpa_ctrl_t          left_amplifier_control_o,
  output hpa_pkg::hpa_ctrl_t          right_amplifier_control_o,
  output logic      [HPA_GAIN_W-1:0]  left_gain_code_o,
  output logic      [HPA_GAIN_W-1:0]  right_gain_code_o,
  output logic                        single_rail_select_o,
  output logic                        differential_output_select_o,
  output logic                        key_open_o
);
  import hpa_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_ff;
  // only the second flop feeds the resets; the first may still be settling
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  hpa_ctrl_t             ctrl_ff     [2];
  logic [HPA_GAIN_W-1:0] gain_ff     [2];
  logic [7:0]            cfg_ff;
  logic [7:0]            key_ff;
  logic                  key_open_ff;
  logic [7:0]            rdata_ff;
  logic                  rvalid_ff;
  hpa_ctrl_t             nxt_ctrl    [2];
  logic [HPA_GAIN_W-1:0] nxt_gain    [2];
  logic [7:0]            nxt_cfg;
  logic [7:0]            nxt_key;
  logic                  nxt_key_open;
  logic [7:0]            nxt_rdata;
  logic                  nxt_rvalid;

  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_gain     = gain_ff;
    nxt_cfg      = cfg_ff;
    nxt_key      = key_ff;
    nxt_key_open = key_open_ff;
    if (wr_en_i) begin
      case (addr_i)
        HPA_OFS_LEFT_CTRL:  nxt_ctrl[0] = hpa_ctrl_t'(wdata_i & HPA_CTRL_MASK);
        HPA_OFS_LEFT_GAIN:  nxt_gain[0] = wdata_i[HPA_GAIN_W-1:0];
        HPA_OFS_RIGHT_CTRL: nxt_ctrl[1] = hpa_ctrl_t'(wdata_i & HPA_CTRL_MASK);
        // reserved codes are kept as written; the host keeps them out
        // right gain store
        HPA_OFS_RIGHT_GAIN: nxt_gain[1] = wdata_i[HPA_GAIN_W-1:0];
        HPA_OFS_OUT_CFG: begin
          nxt_cfg[HPA_CFG_DIFF_BIT] = wdata_i[HPA_CFG_DIFF_BIT];
          if (key_open_ff) begin
            nxt_cfg[HPA_CFG_SINGLE_BIT] = wdata_i[HPA_CFG_SINGLE_BIT];
          end
        end
        HPA_OFS_KEY: begin
          // key stays open until another value lands here; reset leaves it shut
          // key compare
          nxt_key      = wdata_i;
          nxt_key_open = (wdata_i == HPA_KEY_VALUE);
        end
        default: ;
      endcase
    end
  end

  // read data is held in a flop until the next read strobe
  always_comb begin
    nxt_rdata  = rdata_ff;
    nxt_rvalid = rd_en_i;
    if (rd_en_i) begin
      case (addr_i)
        HPA_OFS_LEFT_CTRL:  nxt_rdata = ctrl_ff[0] & HPA_CTRL_MASK;
        HPA_OFS_LEFT_GAIN:  nxt_rdata = {2'h0, gain_ff[0]};
        HPA_OFS_RIGHT_CTRL: nxt_rdata = ctrl_ff[1] & HPA_CTRL_MASK;
        HPA_OFS_RIGHT_GAIN: nxt_rdata = {2'h0, gain_ff[1]};
        HPA_OFS_OUT_CFG:    nxt_rdata = cfg_ff & HPA_CFG_MASK;
        // write-only key reads back as zero
        HPA_OFS_KEY:        nxt_rdata = 8'h00;
        default:            nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_ff[0]  <= hpa_ctrl_t'(HPA_CTRL_RST);
      ctrl_ff[1]  <= hpa_ctrl_t'(HPA_CTRL_RST);
      gain_ff[0]  <= LEFT_GAIN_RST;
      gain_ff[1]  <= HPA_GAIN_RST_R;
      cfg_ff      <= HPA_CFG_RST;
      key_ff      <= HPA_KEY_RST;
      key_open_ff <= 1'b0;
      rdata_ff    <= 8'h00;
      rvalid_ff   <= 1'b0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      gain_ff     <= nxt_gain;
      cfg_ff      <= nxt_cfg;
      key_ff      <= nxt_key;
      key_open_ff <= nxt_key_open;
      rdata_ff    <= nxt_rdata;
      rvalid_ff   <= nxt_rvalid;
    end
  end

  // glide pacing: one code step per tick keeps the change free of clicks
  // free running, so the first step lands 1 to GLIDE_CYCLES cycles after enable
  localparam int GW = $clog2(GLIDE_CYCLES + 1);
  logic [GW-1:0] tick_cnt_ff;
  logic [GW-1:0] nxt_tick_cnt;
  logic          tick;
  always_comb begin
    tick         = (tick_cnt_ff == GW'(GLIDE_CYCLES - 1));
    nxt_tick_cnt = tick ? '0 : tick_cnt_ff + GW'(1);
  end
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  logic [HPA_GAIN_W-1:0] applied_ff [2];
  logic [HPA_GAIN_W-1:0] nxt_applied [2];
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [HPA_GAIN_W-1:0] target;
    always_comb begin
      // lowest gain hold; lowest defined code is -57 dB
      target          = ctrl_ff[ch].hold_lowest_gain ? HPA_GAIN_MIN : gain_ff[ch];
      nxt_applied[ch] = applied_ff[ch];
      // a target moved mid-glide is chased from the current code
      // glide wins over zero crossing
      if (ctrl_ff[ch].glide) begin
        if (tick && applied_ff[ch] < target) begin
          nxt_applied[ch] = applied_ff[ch] + 6'h01;
        end else if (tick && applied_ff[ch] > target) begin
          nxt_applied[ch] = applied_ff[ch] - 6'h01;
        end
      // the crossing pulse comes from the audio path on this same clock
      // change at zero crossing
      end else if (ctrl_ff[ch].gain_at_zero_crossing) begin
        if (zero_cross_i[ch]) begin
          nxt_applied[ch] = target;
        end
      end else begin
        nxt_applied[ch] = target;
      end
    end
    always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
        // starts at the stored reset code, so nothing glides after reset
        applied_ff[ch] <= (ch == 0) ? LEFT_GAIN_RST : HPA_GAIN_RST_R;
      end else begin
        applied_ff[ch] <= nxt_applied[ch];
      end
    end
  end

  // every output is a flop, so no path runs from the strobes to the pins
  assign rdata_o                      = rdata_ff;
  assign rvalid_o                     = rvalid_ff;
  assign left_amplifier_control_o     = ctrl_ff[0];
  assign right_amplifier_control_o    = ctrl_ff[1];
  assign left_gain_code_o             = applied_ff[0];
  assign right_gain_code_o            = applied_ff[1];
  assign single_rail_select_o         = cfg_ff[HPA_CFG_SINGLE_BIT];
  assign differential_output_select_o = cfg_ff[HPA_CFG_DIFF_BIT];
  assign key_open_o                   = key_open_ff;
endmodule
`default_nettype wire

/* File: core/hpa_pkg.sv */
// headphone amplifier control bank: offsets, field layout, reset values
// assumes the serial control front end decodes 8-bit register offsets
`default_nettype none
package hpa_pkg;
  localparam logic [7:0] HPA_OFS_LEFT_CTRL  = 8'hD0;
  localparam logic [7:0] HPA_OFS_LEFT_GAIN  = 8'hD1;
  localparam logic [7:0] HPA_OFS_RIGHT_CTRL = 8'hD2;
  localparam logic [7:0] HPA_OFS_RIGHT_GAIN = 8'hD3;
  localparam logic [7:0] HPA_OFS_OUT_CFG    = 8'hD5;
  localparam logic [7:0] HPA_OFS_KEY        = 8'hD7;

  localparam int         HPA_GAIN_W         = 6;
  localparam logic [5:0] HPA_GAIN_RST_R     = 6'h3B;
  localparam logic [5:0] HPA_GAIN_RST_L     = 6'h3B;
  localparam logic [5:0] HPA_GAIN_MIN       = 6'h15;
  localparam logic [7:0] HPA_CTRL_RST       = 8'h40;
  localparam logic [7:0] HPA_KEY_VALUE      = 8'hC3;
  localparam logic [7:0] HPA_KEY_RST        = 8'hC3;
  localparam int         HPA_CFG_SINGLE_BIT = 4;
  localparam int         HPA_CFG_DIFF_BIT   = 0;
  localparam logic [7:0] HPA_CFG_MASK       = 8'h11;
  localparam logic [7:0] HPA_CFG_RST        = 8'h00;
  localparam logic [7:0] HPA_CTRL_MASK      = 8'hFC;
  localparam logic [7:0] HPA_GAIN_MASK      = 8'h3F;
  localparam int         HPA_GLIDE_CYCLES   = 256;

  typedef struct packed {
    logic       amp_on;
    logic       silence;
    logic       glide;
    logic       gain_at_zero_crossing;
    logic       output_drive;
    logic       hold_lowest_gain;
    logic [1:0] unused;
  } hpa_ctrl_t;
endpackage
`default_nettype wire

/* File: tb/hpa_monitor.sv */
// checker for the headphone amplifier bank ports
// assumes one clock domain; bound onto hpa_regs below
`default_nettype none
module hpa_monitor
  import hpa_pkg::*;
(
  input wire logic               core_clk_i,
  input wire logic               resetn_i,
  input wire logic               wr_en_i,
  input wire logic               rd_en_i,
  input wire logic [7:0]         addr_i,
  input wire logic [7:0]         wdata_i,
  input wire logic [1:0]         zero_cross_i,
  input wire logic [7:0]         rdata_o,
  input wire logic               rvalid_o,
  input wire hpa_pkg::hpa_ctrl_t left_amplifier_control_o,
  input wire hpa_pkg::hpa_ctrl_t right_amplifier_control_o,
  input wire logic [5:0]         left_gain_code_o,
  input wire logic [5:0]         right_gain_code_o,
  input wire logic               single_rail_select_o,
  input wire logic               differential_output_select_o,
  input wire logic               key_open_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic r_hold = right_amplifier_control_o.hold_lowest_gain;
  wire logic r_zc   = right_amplifier_control_o.gain_at_zero_crossing;
  wire logic r_pl   = !right_amplifier_control_o.glide && !r_zc;
  wire logic cfg_wr = wr_en_i && addr_i == HPA_OFS_OUT_CFG;
  sequence s_gain_wr;
    wr_en_i && addr_i == HPA_OFS_RIGHT_GAIN && r_pl && !r_hold ##1 r_pl && !r_hold;
  endsequence
  sequence s_zc_idle;
    (!right_amplifier_control_o.glide && r_zc && !zero_cross_i[1]) [*2];
  endsequence
  right_ctrl_a: assert property (wr_en_i && addr_i == HPA_OFS_RIGHT_CTRL |=>
    right_amplifier_control_o == ($past(wdata_i) & HPA_CTRL_MASK)) else $error("right ctrl");
  left_ctrl_a: assert property (wr_en_i && addr_i == HPA_OFS_LEFT_CTRL |=>
    left_amplifier_control_o == ($past(wdata_i) & HPA_CTRL_MASK)) else $error("left ctrl");
  rail_locked_a: assert property (cfg_wr && !key_open_o |=>
    $stable(single_rail_select_o)) else $error("rail changed while locked");
  rail_open_a: assert property (cfg_wr && key_open_o |=>
    single_rail_select_o == $past(wdata_i[4])) else $error("rail write lost");
  diff_sel_a: assert property (cfg_wr |=>
    differential_output_select_o == $past(wdata_i[0])) else $error("diff write lost");
  key_read_a: assert property (rd_en_i && addr_i == HPA_OFS_KEY |=>
    rvalid_o && rdata_o == 8'h00) else $error("key read not zero");
  gain_now_a: assert property (s_gain_wr |=>
    right_gain_code_o == $past(wdata_i[5:0], 2)) else $error("gain not applied");
  hold_min_a: assert property ((r_hold && r_pl) [*2] |->
    right_gain_code_o == HPA_GAIN_MIN) else $error("hold not lowest");
  zc_wait_a: assert property (s_zc_idle |=>
    $stable(right_gain_code_o)) else $error("gain moved off zero cross");
  glide_step_a: assert property (right_amplifier_control_o.glide |=>
    $stable(right_gain_code_o) || right_gain_code_o == $past(right_gain_code_o) + 6'h01 ||
    right_gain_code_o == $past(right_gain_code_o) - 6'h01) else $error("glide jumped");
endmodule
bind hpa_regs hpa_monitor i_mon (.*);
`default_nettype wire

/* File: tb/hpa_host.sv */
// host model on the register strobe port
// assumes inputs driven at the falling edge
`default_nettype none
module hpa_host (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    {wr_en_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge core_clk_i);
    // released data lines flip so a stale value never looks valid
    {wr_en_o, wdata_o} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(negedge core_clk_i);
    {rd_en_o, addr_o} = {1'b1, a};
    @(negedge core_clk_i);
    rd_en_o = 1'b0;
    for (n = 0; n < 4 && rvalid_i !== 1'b1; n++) @(negedge core_clk_i);
    {ok, d} = {rvalid_i, rdata_i};
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for hpa_regs
// assumes hpa_host and hpa_monitor compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hpa_pkg::*;
  logic clk, rst_n, wr, rd, rv, sgl, dif, key;
  logic [7:0] adr, wd, rdat;
  logic [1:0] zc;
  logic [5:0] lg, rg;
  hpa_ctrl_t lc, rc;
  int error_cnt = 0;
  int checks_done = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  hpa_regs #(.GLIDE_CYCLES(4)) i_dut (.core_clk_i(clk), .resetn_i(rst_n), .wr_en_i(wr),
    .rd_en_i(rd), .addr_i(adr), .wdata_i(wd), .zero_cross_i(zc), .rdata_o(rdat), .rvalid_o(rv),
    .left_amplifier_control_o(lc), .right_amplifier_control_o(rc), .left_gain_code_o(lg),
    .right_gain_code_o(rg), .single_rail_select_o(sgl), .differential_output_select_o(dif),
    .key_open_o(key));
  hpa_host i_host (.core_clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .wr_en_o(wr),
    .rd_en_o(rd), .addr_o(adr), .wdata_o(wd));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_host.rd(a, d, ok);
    check("rvalid", {7'h0, ok}, 8'h01);
    if (ok !== 1'b1) final_report;
    check(n, d, e);
  endtask
  task automatic t_regs;
    check("rctrl", rc, HPA_CTRL_RST);
    check("lctrl", lc, HPA_CTRL_RST);
    check("key", {7'h0, key}, 8'h00);
    rchk("rgain", HPA_OFS_RIGHT_GAIN, 8'h3B);
    rchk("key rd", HPA_OFS_KEY, 8'h00);
    i_host.wr(HPA_OFS_RIGHT_CTRL, 8'hFF);
    rchk("rctrl", HPA_OFS_RIGHT_CTRL, 8'hFC);
    i_host.wr(HPA_OFS_LEFT_CTRL, 8'h88);
    check("lctrl", lc, 8'h88);
    rchk("unmapped", 8'hD4, 8'h00);
    i_host.wr(HPA_OFS_OUT_CFG, 8'h11);
    check("cfg", {3'h0, sgl, 3'h0, dif}, 8'h01);
    i_host.wr(HPA_OFS_KEY, HPA_KEY_VALUE);
    i_host.wr(HPA_OFS_OUT_CFG, 8'h11);
    check("rail", {7'h0, sgl}, 8'h01);
    i_host.wr(HPA_OFS_KEY, 8'h3C);
    i_host.wr(HPA_OFS_OUT_CFG, 8'h01);
    rchk("cfg", HPA_OFS_OUT_CFG, 8'h11);
    $display("register test done");
  endtask
  task automatic t_gain;
    int n;
    i_host.wr(HPA_OFS_RIGHT_CTRL, 8'h00);
    i_host.wr(HPA_OFS_RIGHT_GAIN, 8'h3F);
    i_host.wr(HPA_OFS_LEFT_GAIN, 8'h15);
    check("gains", {rg, 2'h0}, 8'hFC);
    @(negedge clk);
    check("lgain", {2'h0, lg}, 8'h15);
    i_host.wr(HPA_OFS_RIGHT_CTRL, 8'h10);
    i_host.wr(HPA_OFS_RIGHT_GAIN, 8'h20);
    repeat (3) @(negedge clk);
    check("zc wait", {2'h0, rg}, 8'h3F);
    zc = 2'b10;
    @(negedge clk);
    zc = 2'b00;
    repeat (2) @(negedge clk);
    check("zc apply", {2'h0, rg}, 8'h20);
    i_host.wr(HPA_OFS_LEFT_CTRL, 8'h10);
    i_host.wr(HPA_OFS_LEFT_GAIN, 8'h3B);
    repeat (2) @(negedge clk);
    check("lzc wait", {2'h0, lg}, 8'h15);
    zc = 2'b01;
    @(negedge clk);
    zc = 2'b00;
    @(negedge clk);
    check("lzc apply", {2'h0, lg}, 8'h3B);
    i_host.wr(HPA_OFS_RIGHT_CTRL, 8'h04);
    @(negedge clk);
    check("hold", {2'h0, rg}, {2'h0, HPA_GAIN_MIN});
    i_host.wr(HPA_OFS_RIGHT_CTRL, 8'h30);
    check("glide", {7'h0, rg == 6'h20}, 8'h00);
    for (n = 0; n < 200 && rg !== 6'h20; n++) @(negedge clk);
    check("glide end", {2'h0, rg}, 8'h20);
    // 11 code steps, one tick every 4 cycles, first tick 1 to 4 cycles in
    check("glide time", {7'h0, n >= 41 && n <= 44}, 8'h01);
    if (n == 200) final_report;
    $display("gain test done");
  endtask
  initial begin
    {rst_n, zc} = 3'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs;
    t_gain;
    final_report;
  end
endmodule
`default_nettype wire
